// ### tb/crf_alu_model.sv
// Behavioural ALU partner feeding results and branch targets to the register set
`timescale 1ns/1ns
module crf_alu_model
    import crf_pkg::*;
(
    // Operands
    input logic [DATA_W-1:0] opA,
    input logic [DATA_W-1:0] opB,
    input logic subtract,
    input logic [PC_W-1:0] pcIn,
    input logic [7:0] offset,
    // Results
    output logic [DATA_W-1:0] aluResult,
    output logic aluCarry,
    output logic [PC_W-1:0] branchResult
);
    // =====================================
    // Adder
    logic [DATA_W:0] sum;
    always_comb begin
        sum = subtract ? {1'b0, opA} - {1'b0, opB} : {1'b0, opA} + {1'b0, opB};
    end
    assign aluResult = sum[DATA_W-1:0];
    // Borrow of a subtract also lands in the top bit
    assign aluCarry = sum[DATA_W];
    // Offset is signed, so extend before the add
    assign branchResult = pcIn + {{4{offset[7]}}, offset};
endmodule

// ### tb/testbench.sv
// Self-checking bench for the CPU register set
`timescale 1ns/1ns
module testbench;
    import crf_pkg::*;
    // =====================================
    // Signals
    logic clk = 1'b0, rst = 1'b1, instrStart = 1'b0, sdAccess = 1'b0, sdWe = 1'b0;
    logic dsWrite = 1'b0, testedBit = 1'b0, subtract = 1'b0;
    logic cpuCycle, instrDone, aluCarry, carryFlag, zeroFlag, dsHit;
    crf_len_type instrLen = LEN_TWO;
    crf_pcop_type pcOp = PC_HOLD;
    crf_flagop_type flagOp = FL_NONE;
    crf_ctx_type ctxOut;
    logic [1:0] sdSel = 2'h0;
    logic [2:0] cyclesLeft, stackDepth;
    logic [11:0] pcTarget = 12'h000, programCounter, branchResult;
    logic [7:0] dsAddr = 8'h00, dsWdata = 8'h00, sdWdata = 8'h00, opA = 8'h00, opB = 8'h00;
    logic [7:0] offset = 8'h00, aluResult, dsRdata, sdRdata, acc, ixLow, ixHigh, sdA, sdB;
    logic [7:0] addrs[7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF, 8'h84, 8'h7F};
    // Reference state
    int miscompares = 0, checked = 0, pcM = 'hFFE, ctxM = 2, prevIrq = 0, prevNmi = 0;
    int sdM = 0, n;
    int stk[$];
    int cM[3] = '{0, 0, 0};
    int zM[3] = '{0, 0, 0};
    int regM[5] = '{0, 0, 0, 0, 0};

    always #5 clk = ~clk;

    crf_cpu_registers dut (.clk(clk), .rst(rst), .cpuCycle(cpuCycle), .instrStart(instrStart),
        .instrLen(instrLen), .cyclesLeft(cyclesLeft), .instrDone(instrDone), .pcOp(pcOp),
        .pcTarget(pcTarget), .branchResult(branchResult), .programCounter(programCounter),
        .stackDepth(stackDepth), .flagOp(flagOp), .aluResult(aluResult), .aluCarry(aluCarry),
        .testedBit(testedBit), .carryFlag(carryFlag), .zeroFlag(zeroFlag), .execContext(ctxOut),
        .dsAddr(dsAddr), .dsWrite(dsWrite), .dsWdata(dsWdata), .dsRdata(dsRdata),
        .dsHit(dsHit), .sdAccess(sdAccess), .sdSel(sdSel), .sdWe(sdWe), .sdWdata(sdWdata),
        .sdRdata(sdRdata), .accumulator(acc), .indexPointerLow(ixLow),
        .indexPointerHigh(ixHigh), .shortDirectFirst(sdA), .shortDirectSecond(sdB));
    crf_alu_model alu (.opA(opA), .opB(opB), .subtract(subtract), .pcIn(programCounter),
        .offset(offset), .aluResult(aluResult), .aluCarry(aluCarry),
        .branchResult(branchResult));

    // =====================================
    // Helpers
    function automatic int slotOf(input logic [7:0] a);
        if (a == 8'hFF) return 4;
        if (a[7:2] == 6'h20) return int'(a[1:0]);
        return -1;
    endfunction

    task automatic chk(input logic [11:0] got, input int exp, input string what);
        checked++;
        if (got !== 12'(exp)) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, 12'(exp));
        end
    endtask

    // Inputs other than the read address are taken only on the edge that carries a CPU cycle
    task automatic slot();
        @(negedge clk);
        while (cpuCycle !== 1'b1) @(negedge clk);
    endtask

    task automatic idle();
        @(negedge clk);
        pcOp = PC_HOLD;
        flagOp = FL_NONE;
        dsWrite = 1'b0;
        instrStart = 1'b0;
        sdAccess = 1'b0;
    endtask

    task automatic views();
        chk(ixLow, regM[0], "index low");
        chk(ixHigh, regM[1], "index high");
        chk(sdA, regM[2], "short first");
        chk(sdB, regM[3], "short second");
        chk(acc, regM[4], "accumulator");
    endtask

    task automatic mpush(input int tgt);
        stk.push_front(pcM);
        if (stk.size() > 6) void'(stk.pop_back());
        pcM = tgt;
    endtask

    task automatic pcop(input crf_pcop_type op, input int tgt);
        slot();
        pcOp = op;
        pcTarget = 12'(tgt);
        case (op)
            PC_INC: pcM = (pcM + 1) % 4096;
            PC_JUMP: pcM = tgt;
            PC_BRANCH: pcM = (pcM + int'($signed(offset))) & 'hFFF;
            PC_CALL: mpush(tgt);
            PC_IRQ: begin
                prevIrq = ctxM;
                ctxM = 1;
                mpush(tgt);
            end
            PC_NMI: begin
                prevNmi = ctxM;
                ctxM = 2;
                mpush(tgt);
            end
            default: begin
                if (stk.size() > 0) pcM = stk.pop_front();
                if (op == PC_INTERRUPT_EXIT_OP && ctxM == 2) ctxM = prevNmi;
                else if (op == PC_INTERRUPT_EXIT_OP && ctxM == 1) ctxM = prevIrq;
            end
        endcase
        idle();
        chk(programCounter, pcM, "pc");
        chk(stackDepth, stk.size(), "depth");
        chk(ctxOut, ctxM, "context");
        chk(carryFlag, cM[ctxM], "carry bank");
        chk(zeroFlag, zM[ctxM], "zero bank");
        chk(acc, regM[4], "acc kept");
    endtask

    // s bit 0 selects subtract, bit 1 is the tested bit
    task automatic flg(input crf_flagop_type f, input int a, input int b, input int s);
        int r;
        slot();
        flagOp = f;
        opA = 8'(a);
        opB = 8'(b);
        subtract = s[0];
        testedBit = s[1];
        r = s[0] ? a - b : a + b;
        if (f == FL_ARITH) cM[ctxM] = (r < 0 || r > 255);
        if (f == FL_BITTEST) cM[ctxM] = s[1];
        if (f == FL_ARITH || f == FL_LOGIC) zM[ctxM] = ((r & 255) == 0);
        idle();
        chk(carryFlag, cM[ctxM], "carry");
        chk(zeroFlag, zM[ctxM], "zero");
    endtask

    task automatic dsw(input logic [7:0] a, input logic [7:0] d);
        slot();
        dsAddr = a;
        dsWrite = 1'b1;
        dsWdata = d;
        if (slotOf(a) >= 0) regM[slotOf(a)] = d;
        idle();
        @(negedge clk);
        chk(dsRdata, slotOf(a) >= 0 ? regM[slotOf(a)] : 0, "read back");
        chk(dsHit, slotOf(a) >= 0, "hit");
        views();
    endtask

    task automatic instr(input crf_len_type len, input int sdx, input int sel, input int we,
        input logic [7:0] d);
        int cyc;
        cyc = sdx ? 4 : (len == LEN_TWO ? 2 : (len == LEN_FOUR ? 4 : 5));
        slot();
        instrStart = 1'b1;
        instrLen = len;
        sdAccess = sdx[0];
        sdSel = 2'(sel);
        sdWe = we[0];
        sdWdata = d;
        if (sdx) sdM = regM[sel];
        if (sdx && we) regM[sel] = d;
        idle();
        chk(cyclesLeft, cyc - 1, "cycles left");
        n = 0;
        while (instrDone !== 1'b1 && n < 80) begin
            @(negedge clk);
            n++;
        end
        chk(n, 13 * (cyc - 1), "length");
        chk(sdRdata, sdM, "short read");
        views();
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // =====================================
    // Tests
    initial begin
        void'($urandom(23));
        repeat (5) @(negedge clk);
        rst = 1'b0;
        chk(programCounter, 'hFFE, "reset pc");
        chk(ctxOut, 2, "reset context");
        chk(stackDepth, 0, "reset depth");
        slot();
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cpuCycle !== 1'b1 && n < 30);
        chk(n, 13, "cycle period");
        foreach (addrs[i]) dsw(addrs[i], 8'($urandom()));
        flg(FL_ARITH, 200, 100, 0);
        pcop(PC_INTERRUPT_EXIT_OP, 0);
        flg(FL_ARITH, 5, 5, 1);
        flg(FL_ARITH, 3, 5, 1);
        flg(FL_LOGIC, 9, 0, 0);
        pcop(PC_IRQ, 'hFF0);
        flg(FL_BITTEST, 0, 0, 2);
        pcop(PC_NMI, 'hFFC);
        pcop(PC_INTERRUPT_EXIT_OP, 0);
        pcop(PC_INTERRUPT_EXIT_OP, 0);
        repeat (6) flg(crf_flagop_type'($urandom_range(3)), $urandom_range(255),
            $urandom_range(255), $urandom_range(3));
        pcop(PC_INC, 0);
        pcop(PC_JUMP, $urandom_range(4095));
        offset = 8'hF0;
        pcop(PC_BRANCH, 0);
        offset = 8'h25;
        pcop(PC_BRANCH, 0);
        for (int i = 0; i < 7; i++) pcop(PC_CALL, 'h100 + i);
        repeat (6) pcop(PC_RET, 0);
        pcop(PC_RET, 0);
        for (int i = 0; i < 4; i++) instr(LEN_FIVE, 1, i, 1, 8'($urandom()));
        instr(LEN_FOUR, 1, 2, 0, 8'h00);
        instr(LEN_TWO, 0, 0, 0, 8'h00);
        instr(LEN_FIVE, 0, 0, 0, 8'h00);
        tally_and_finish();
    end

    // Whole run needs under a thousand clock cycles
    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
endmodule

// ### verilog/crf_cpu_registers.sv
// CPU programmer-visible registers, banked flags, program counter, stack
`timescale 1ns/1ns
// =====================================================
// What this block does
// - Accumulator also answers at data-space address FFh.
// - Index pointers sit at 80h and 81h, reachable by all modes.
// - Short-direct registers sit at 82h and 83h, reachable by all modes.
// - Short direct access is a one-byte, four-cycle instruction.
// - Program counter is 12 bits, covering 4096 program bytes.
// - PC increments, loads jump targets, takes branch results, pops on return.
// - Three carry/zero pairs: normal, interrupt, NMI; only current one used.
// - Interrupt or NMI entry switches pair; interrupt return restores previous.
// - Flags keep their values across every context switch.
// - Instructions touch only the current context's flag pair.
// - Carry follows arithmetic carry/borrow, tested bit, and feeds rotate left.
// - Zero set when last arithmetic or logic result is zero.
// - After reset the NMI flag pair is in use.
// - Return stack has six 12-bit levels and no visible pointer.
// - Call or interrupt shifts levels down and pushes PC on top.
// - Return loads PC from top and shifts the rest upward.
// - Nesting beyond six keeps the stack deepest, losing oldest entry.
// - Return with empty stack leaves it empty; execution simply continues.
// - Only the PC is pushed; data registers are never saved.
// - Instructions last two, four or five CPU cycles.
// - CPU cycle enable is the core clock divided by 13.
// - Reset empties the stack and loads PC with 0FFEh.
// - Reset selects NMI context until the first interrupt return.
module crf_cpu_registers
    import crf_pkg::*;
(
    // Clock and reset
    input logic clk,
    input logic rst,
    // Cycle timing
    output logic cpuCycle,
    input logic instrStart,
    input crf_len_type instrLen,
    output logic [2:0] cyclesLeft,
    output logic instrDone,
    // Program counter control
    input crf_pcop_type pcOp,
    input logic [PC_W-1:0] pcTarget,
    input logic [PC_W-1:0] branchResult,
    output logic [PC_W-1:0] programCounter,
    output logic [2:0] stackDepth,
    // Flag updates from the ALU
    input crf_flagop_type flagOp,
    input logic [DATA_W-1:0] aluResult,
    input logic aluCarry,
    input logic testedBit,
    output logic carryFlag,
    output logic zeroFlag,
    output crf_ctx_type execContext,
    // Data-space bus
    input logic [7:0] dsAddr,
    input logic dsWrite,
    input logic [DATA_W-1:0] dsWdata,
    output logic [DATA_W-1:0] dsRdata,
    output logic dsHit,
    // Short direct access
    input logic sdAccess,
    input logic [1:0] sdSel,
    input logic sdWe,
    input logic [DATA_W-1:0] sdWdata,
    output logic [DATA_W-1:0] sdRdata,
    // Register views
    output logic [DATA_W-1:0] accumulator,
    output logic [DATA_W-1:0] indexPointerLow,
    output logic [DATA_W-1:0] indexPointerHigh,
    output logic [DATA_W-1:0] shortDirectFirst,
    output logic [DATA_W-1:0] shortDirectSecond
);
    // =====================================================
    // Declarations
    logic [DATA_W-1:0] regFile_reg [REG_COUNT];
    logic [2:0] dsSlot;
    logic sdPending_reg;
    logic [1:0] sdSel_reg;
    logic sdWe_reg;
    logic [DATA_W-1:0] sdWdata_reg;
    logic sdCommit;
    crf_ctx_type ctx_next;
    crf_ctx_type irqPrev_reg;
    crf_ctx_type irqPrev_next;
    crf_ctx_type nmiPrev_reg;
    crf_ctx_type nmiPrev_next;
    logic [2:0] carry_reg;
    logic [2:0] carry_next;
    logic [2:0] zero_reg;
    logic [2:0] zero_next;
    logic [PC_W-1:0] pc_next;
    logic stackPush;
    logic stackPop;
    logic [PC_W-1:0] stackTop;
    logic stackEmpty;

    function automatic logic [2:0] regSlot(input logic [7:0] addr);
        case (addr)
            ADDR_INDEX_LOW: regSlot = SLOT_INDEX_LOW;
            ADDR_INDEX_HIGH: regSlot = SLOT_INDEX_HIGH;
            ADDR_SHORT_FIRST: regSlot = SLOT_SHORT_FIRST;
            ADDR_SHORT_SECOND: regSlot = SLOT_SHORT_SECOND;
            ADDR_ACCUMULATOR: regSlot = SLOT_ACCUMULATOR;
            default: regSlot = SLOT_NONE;
        endcase
    endfunction

    function automatic logic [2:0] lenCycles(input crf_len_type len);
        case (len)
            LEN_TWO: lenCycles = CYC_TWO;
            LEN_FIVE: lenCycles = CYC_FIVE;
            default: lenCycles = CYC_FOUR;
        endcase
    endfunction

    // =====================================================
    // Cycle enable
    crf_cycle_divider #(
        .DIV(CLK_DIV)
    ) cycleDivider (
        .clk(clk),
        .rst(rst),
        .tick(cpuCycle)
    );

    // =====================================================
    // Instruction cycle counter
    // A start while busy is ignored; the next one may come on the
    // CPU cycle after the last.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cyclesLeft <= 3'h0;
            instrDone <= 1'b0;
        end else begin
            instrDone <= cpuCycle && cyclesLeft == 3'h1;
            if (cpuCycle) begin
                if (cyclesLeft != 3'h0) begin
                    cyclesLeft <= cyclesLeft - 3'h1;
                end else if (instrStart) begin
                    // Start cycle is the first CPU cycle
                    cyclesLeft <= (sdAccess ? CYC_FOUR : lenCycles(instrLen)) - 3'h1;
                end
            end
        end
    end

    // =====================================================
    // Short direct request capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdPending_reg <= 1'b0;
            sdSel_reg <= 2'h0;
            sdWe_reg <= 1'b0;
            sdWdata_reg <= REG_RESET;
        end else if (cpuCycle) begin
            if (cyclesLeft == 3'h0 && instrStart && sdAccess) begin
                sdPending_reg <= 1'b1;
                sdSel_reg <= sdSel;
                sdWe_reg <= sdWe;
                sdWdata_reg <= sdWdata;
            end else if (cyclesLeft == 3'h1) begin
                sdPending_reg <= 1'b0;
            end
        end
    end

    assign sdCommit = cpuCycle && cyclesLeft == 3'h1 && sdPending_reg;
    assign dsSlot = regSlot(dsAddr);

    // =====================================================
    // Data registers
    // Short direct wins if both writers hit the same register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regFile_reg[i] <= REG_RESET;
            end
        end else if (cpuCycle) begin
            if (dsWrite && dsSlot != SLOT_NONE) begin
                regFile_reg[dsSlot] <= dsWdata;
            end
            if (sdCommit && sdWe_reg) begin
                regFile_reg[{1'b0, sdSel_reg}] <= sdWdata_reg;
            end
        end
    end

    assign accumulator = regFile_reg[SLOT_ACCUMULATOR];
    assign indexPointerLow = regFile_reg[SLOT_INDEX_LOW];
    assign indexPointerHigh = regFile_reg[SLOT_INDEX_HIGH];
    assign shortDirectFirst = regFile_reg[SLOT_SHORT_FIRST];
    assign shortDirectSecond = regFile_reg[SLOT_SHORT_SECOND];

    // =====================================================
    // Read ports
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dsRdata <= REG_RESET;
            dsHit <= 1'b0;
            sdRdata <= REG_RESET;
        end else begin
            dsHit <= dsSlot != SLOT_NONE;
            dsRdata <= (dsSlot != SLOT_NONE) ? regFile_reg[dsSlot] : REG_RESET;
            if (sdCommit) begin
                sdRdata <= regFile_reg[{1'b0, sdSel_reg}];
            end
        end
    end

    // =====================================================
    // Context and banked flags
    always_comb begin
        ctx_next = execContext;
        irqPrev_next = irqPrev_reg;
        nmiPrev_next = nmiPrev_reg;
        carry_next = carry_reg;
        zero_next = zero_reg;
        if (cpuCycle) begin
            // Only the running context's pair is ever written
            case (flagOp)
                FL_ARITH: begin
                    carry_next[execContext] = aluCarry;
                    zero_next[execContext] = (aluResult == '0);
                end
                FL_LOGIC: begin
                    zero_next[execContext] = (aluResult == '0);
                end
                FL_BITTEST: begin
                    carry_next[execContext] = testedBit;
                end
                default: begin
                end
            endcase
            case (pcOp)
                PC_IRQ: begin
                    irqPrev_next = execContext;
                    ctx_next = CTX_IRQ;
                end
                PC_NMI: begin
                    nmiPrev_next = execContext;
                    ctx_next = CTX_NMI;
                end
                PC_INTERRUPT_EXIT_OP: begin
                    case (execContext)
                        CTX_NMI: ctx_next = nmiPrev_reg;
                        CTX_IRQ: ctx_next = irqPrev_reg;
                        default: ctx_next = CTX_NORMAL;
                    endcase
                end
                default: begin
                end
            endcase
        end
    end

    // Flags are never cleared on a switch, only bank selection moves
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            execContext <= CTX_NMI;
            irqPrev_reg <= CTX_NORMAL;
            nmiPrev_reg <= CTX_NORMAL;
            carry_reg <= 3'h0;
            zero_reg <= 3'h0;
            carryFlag <= 1'b0;
            zeroFlag <= 1'b0;
        end else begin
            execContext <= ctx_next;
            irqPrev_reg <= irqPrev_next;
            nmiPrev_reg <= nmiPrev_next;
            carry_reg <= carry_next;
            zero_reg <= zero_next;
            carryFlag <= carry_next[ctx_next];
            zeroFlag <= zero_next[ctx_next];
        end
    end

    // =====================================================
    // Program counter
    always_comb begin
        pc_next = programCounter;
        stackPush = 1'b0;
        stackPop = 1'b0;
        if (cpuCycle) begin
            case (pcOp)
                PC_INC: pc_next = programCounter + PC_STEP;
                PC_JUMP: pc_next = pcTarget;
                PC_BRANCH: pc_next = branchResult;
                PC_CALL, PC_IRQ, PC_NMI: begin
                    pc_next = pcTarget;
                    stackPush = 1'b1;
                end
                PC_RET, PC_INTERRUPT_EXIT_OP: begin
                    stackPop = 1'b1;
                    // Empty stack: keep going from the current address
                    pc_next = stackEmpty ? programCounter : stackTop;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            programCounter <= RESET_VECTOR;
        end else begin
            programCounter <= pc_next;
        end
    end

    crf_return_stack #(
        .DEPTH(STACK_DEPTH),
        .WIDTH(PC_W)
    ) returnStack (
        .clk(clk),
        .rst(rst),
        .push(stackPush),
        .pop(stackPop),
        .pushData(programCounter),
        .topData(stackTop),
        .depth(stackDepth),
        .empty(stackEmpty)
    );

    // =====================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence sdStartSeq;
        cpuCycle && instrStart && sdAccess && cyclesLeft == 3'h0;
    endsequence

    sequence sdRunSeq;
        ##1 cyclesLeft == 3'h3 ##39 instrDone;
    endsequence

    chk_acc_write: assert property (
        (cpuCycle && dsWrite && dsAddr == ADDR_ACCUMULATOR)
        |=> accumulator == $past(dsWdata))
        else $error("accumulator not written through data space");

    chk_index_read: assert property (
        dsAddr == ADDR_INDEX_HIGH |=> dsHit && dsRdata == $past(indexPointerHigh))
        else $error("index pointer read mismatch");

    chk_short_read: assert property (
        dsAddr == ADDR_SHORT_FIRST |=> dsHit && dsRdata == $past(shortDirectFirst))
        else $error("short direct register read mismatch");

    chk_sd_four: assert property (sdStartSeq |-> sdRunSeq)
        else $error("short direct access did not last four cycles");

    chk_pc_inc: assert property (
        (cpuCycle && pcOp == PC_INC) |=> programCounter == $past(programCounter) + PC_STEP)
        else $error("program counter did not advance by one");

    chk_interrupt_exit_op_ctx: assert property (
        (cpuCycle && pcOp == PC_INTERRUPT_EXIT_OP && execContext == CTX_NMI)
        |=> execContext == $past(nmiPrev_reg))
        else $error("interrupt return chose wrong context");

    chk_bank_keep: assert property (
        execContext != CTX_NORMAL |=> carry_reg[0] == $past(carry_reg[0])
            && zero_reg[0] == $past(zero_reg[0]))
        else $error("normal flags changed outside normal context");

    chk_zero_flag: assert property (
        (cpuCycle && flagOp == FL_ARITH && pcOp == PC_HOLD)
        |=> zeroFlag == ($past(aluResult) == '0))
        else $error("zero flag wrong after arithmetic");

    chk_carry_bit: assert property (
        (cpuCycle && flagOp == FL_BITTEST && pcOp == PC_HOLD)
        |=> carryFlag == $past(testedBit))
        else $error("carry flag did not take tested bit");

    chk_call_push: assert property (
        (cpuCycle && pcOp == PC_CALL)
        |=> programCounter == $past(pcTarget) && stackTop == $past(programCounter))
        else $error("call did not push return address");

    chk_ret_empty: assert property (
        (cpuCycle && pcOp == PC_RET && stackEmpty)
        |=> programCounter == $past(programCounter) && stackEmpty)
        else $error("return on empty stack moved the stack or PC");
endmodule

// ### verilog/crf_cycle_divider.sv
// CPU cycle enable generator
`timescale 1ns/1ns
module crf_cycle_divider
    import crf_pkg::*;
#(
    parameter int DIV = CLK_DIV
)
(
    // Clock and reset
    input logic clk,
    input logic rst,
    // Enable out
    output logic tick
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] count_reg;

    // =====================================================
    // Divider
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (count_reg == LAST);
            if (count_reg == LAST) begin
                count_reg <= '0;
            end else begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    chk_tick_period: assert property (@(posedge clk) disable iff (rst)
        tick |-> ##1 (!tick) [*8] ##1 (!tick) [*4] ##1 tick)
        else $error("cycle enable period is not thirteen clocks");
endmodule

// ### verilog/crf_pkg.sv
// Shared constants and types for the CPU register set
package crf_pkg;
    // =====================================================
    // Widths and sizes
    localparam int DATA_W = 8;
    localparam int PC_W = 12;
    localparam int STACK_DEPTH = 6;
    localparam int CLK_DIV = 13;
    localparam int REG_COUNT = 5;
    // =====================================================
    // Data-space map
    localparam logic [7:0] ADDR_INDEX_LOW = 8'h80;
    localparam logic [7:0] ADDR_INDEX_HIGH = 8'h81;
    localparam logic [7:0] ADDR_SHORT_FIRST = 8'h82;
    localparam logic [7:0] ADDR_SHORT_SECOND = 8'h83;
    localparam logic [7:0] ADDR_ACCUMULATOR = 8'hFF;
    localparam logic [2:0] SLOT_INDEX_LOW = 3'h0;
    localparam logic [2:0] SLOT_INDEX_HIGH = 3'h1;
    localparam logic [2:0] SLOT_SHORT_FIRST = 3'h2;
    localparam logic [2:0] SLOT_SHORT_SECOND = 3'h3;
    localparam logic [2:0] SLOT_ACCUMULATOR = 3'h4;
    localparam logic [2:0] SLOT_NONE = 3'h7;
    localparam logic [7:0] REG_RESET = 8'h00;
    // =====================================================
    // Program counter and instruction timing
    localparam logic [11:0] RESET_VECTOR = 12'hFFE;
    localparam logic [11:0] PC_STEP = 12'h001;
    localparam logic [2:0] CYC_TWO = 3'h2;
    localparam logic [2:0] CYC_FOUR = 3'h4;
    localparam logic [2:0] CYC_FIVE = 3'h5;
    // =====================================================
    // Types
    typedef enum logic [3:0] {
        PC_HOLD, PC_INC, PC_JUMP, PC_CALL, PC_BRANCH,
        PC_RET, PC_INTERRUPT_EXIT_OP, PC_IRQ, PC_NMI
    } crf_pcop_type;
    typedef enum logic [1:0] {CTX_NORMAL, CTX_IRQ, CTX_NMI} crf_ctx_type;
    typedef enum logic [1:0] {LEN_TWO, LEN_FOUR, LEN_FIVE} crf_len_type;
    typedef enum logic [1:0] {FL_NONE, FL_ARITH, FL_LOGIC, FL_BITTEST} crf_flagop_type;
endpackage

// ### verilog/crf_return_stack.sv
// Six-level shifting return stack
`timescale 1ns/1ns
module crf_return_stack
    import crf_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int WIDTH = PC_W
)
(
    // Clock and reset
    input logic clk,
    input logic rst,
    // Requests
    input logic push,
    input logic pop,
    input logic [WIDTH-1:0] pushData,
    // State
    output logic [WIDTH-1:0] topData,
    output logic [$clog2(DEPTH+1)-1:0] depth,
    output logic empty
);
    localparam int DW = $clog2(DEPTH + 1);
    localparam logic [DW-1:0] FULL_COUNT = DW'(DEPTH);

    logic [WIDTH-1:0] levels_reg [DEPTH];

    assign topData = levels_reg[0];
    assign empty = (depth == '0);

    // =====================================================
    // Shift register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                levels_reg[i] <= '0;
            end
            depth <= '0;
        end else if (push) begin
            levels_reg[0] <= pushData;
            for (int i = 1; i < DEPTH; i++) begin
                levels_reg[i] <= levels_reg[i-1];
            end
            // Deepest entry simply falls off
            if (depth != FULL_COUNT) begin
                depth <= depth + 1'b1;
            end
        end else if (pop && !empty) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                levels_reg[i] <= levels_reg[i+1];
            end
            levels_reg[DEPTH-1] <= '0;
            depth <= depth - 1'b1;
        end
    end

    chk_depth_saturates: assert property (@(posedge clk) disable iff (rst)
        (push && depth == FULL_COUNT) |=> depth == FULL_COUNT)
        else $error("stack depth left saturation on overflow");
endmodule
